/* File: core/acb_coef_bank.v */
// Paged ADC coefficient double-buffer register bank with an Avalon-MM slave
// Overview of operation
// - Register 0 of every page is an 8-bit page select that steers all later accesses.
// - Configuration bit D2 turns ADC adaptive filtering on, resets to 0 so it starts off.
// - Read-only bit D1 tells which bank the ADC uses in adaptive mode, the host getting the other one.
// - Writing 1 to D0 with adaptive mode on asks for a bank exchange at the next frame.
// - The exchange clears D0 by itself and toggles the ownership flag at that moment.
// - Registers 8 to 127 of the first page hold 24-bit coefficients 0 to 29, no reset.
// - With adaptive mode off, coefficients are reachable only while the ADC is off.
// - Reserved registers 2 to 7 and config bits D7 to D3 read zero, host writes zero.
// - Pages 9 to 16 continue the first bank with coefficients 30 to 255, same limits.
// - Pages 26 to 34 hold the second bank, 0 to 255, all sharing the one page select register.
`timescale 1ns/1ps
`include "acb_regs.vh"

module acb_coef_bank (
  input wire CLK_SYS,
  input wire NRST,
  input wire [6:0] ADDRESS,
  input wire READ,
  input wire WRITE,
  input wire [3:0] BYTEENABLE,
  input wire [31:0] WRITEDATA,
  output reg [31:0] READDATA,
  output reg WAITREQUEST,
  input wire ADC_POWERED,
  input wire FRAME_SYNC,
  input wire [7:0] DP_COEF_INDEX,
  output wire [23:0] DP_COEF,
  output reg ADAPTIVE_EN,
  output reg BANK_FLAG,
  output reg SWAP_PENDING,
  output reg ACCESS_DENIED
);

  // Bus handshake state and the page select
  reg [1:0] state;
  reg [7:0] page;

  // Staged upper bytes of the coefficient being written
  reg [7:0] stage_hi;
  reg [7:0] stage_mid;

  // Address decode results
  reg is_page_sel;
  reg is_cfg;
  reg is_rsvd;
  reg in_first;
  reg in_second;
  reg page_bank;
  reg [3:0] page_rel;
  reg [7:0] page_off;
  reg [6:0] coef_off;
  reg [4:0] slot;
  reg [1:0] lane;
  reg [8:0] coef_idx;
  reg coef_hit;
  reg grant;
  reg coef_ok;
  reg phys_bank;
  reg [7:0] rd_byte;

  // Memory side
  wire [23:0] host_rdata;
  wire [8:0] host_addr;
  wire [8:0] dp_addr;
  wire mem_we;

  // Bus write qualifiers taken at the acknowledge edge
  wire wr_take;
  wire cfg_wr;
  wire swap_do;
  wire swap_set;

  // Page window decode
  always @* begin
    in_first = 1'b0;
    in_second = 1'b0;
    page_bank = 1'b0;
    page_rel = 4'h0;
    page_off = 8'h00;
    // Full-width offset first; at most nine pages per bank, so four bits are enough
    if ((page >= `ACB_PAGE_FIRST_LO) && (page <= `ACB_PAGE_FIRST_HI)) begin
      in_first = 1'b1;
      page_off = page - `ACB_PAGE_FIRST_LO;
      page_rel = page_off[3:0];
    end else if ((page >= `ACB_PAGE_SECOND_LO) && (page <= `ACB_PAGE_SECOND_HI)) begin
      in_second = 1'b1;
      page_bank = 1'b1;
      page_off = page - `ACB_PAGE_SECOND_LO;
      page_rel = page_off[3:0];
    end
  end

  // Register decode within the page
  always @* begin
    is_page_sel = (ADDRESS == `ACB_OFS_PAGE_SEL);
    is_cfg = (page == `ACB_PAGE_CFG) && (ADDRESS == `ACB_OFS_CFG);
    is_rsvd = (ADDRESS >= `ACB_OFS_RSVD_FIRST) && (ADDRESS <= `ACB_OFS_RSVD_LAST);
    coef_off = ADDRESS - `ACB_OFS_COEF;
    slot = coef_off[6:2];
    lane = coef_off[1:0];
  end

  // Coefficient index: thirty per page, four byte slots each
  always @* begin
    coef_idx = {5'h00, page_rel} * {4'h0, `ACB_COEF_PER_PAGE} + {4'h0, slot};
    coef_hit = (in_first || in_second) && (ADDRESS >= `ACB_OFS_COEF)
               && (coef_idx <= `ACB_COEF_LAST);
  end

  // Access permission and bank routing
  always @* begin
    // Outside adaptive mode the live bank could be disturbed, so only a powered-down ADC
    grant = ADAPTIVE_EN || !ADC_POWERED;
    coef_ok = coef_hit && grant;
    if (ADAPTIVE_EN) begin
      phys_bank = ~BANK_FLAG;
    end else begin
      phys_bank = page_bank;
    end
  end

  // Read byte selection
  always @* begin
    rd_byte = 8'h00;
    if (is_page_sel) begin
      rd_byte = page;
    end else if (is_cfg) begin
      // Upper bits stay zero as reserved
      rd_byte = {5'h00, ADAPTIVE_EN, BANK_FLAG, SWAP_PENDING};
    end else if (is_rsvd) begin
      rd_byte = 8'h00;
    end else if (coef_ok) begin
      case (lane)
        `ACB_LANE_HI: begin
          rd_byte = host_rdata[23:16];
        end
        `ACB_LANE_MID: begin
          rd_byte = host_rdata[15:8];
        end
        `ACB_LANE_LO: begin
          rd_byte = host_rdata[7:0];
        end
        default: begin
          rd_byte = 8'h00;
        end
      endcase
    end
  end

  // Write qualifiers; only byte lane 0 carries register data
  assign wr_take = (state == `ACB_ST_ACK) && WRITE && BYTEENABLE[0];
  assign cfg_wr = wr_take && is_cfg;

  // Whole coefficient commits only with its last byte
  assign mem_we = wr_take && coef_ok && (lane == `ACB_LANE_LO);
  assign host_addr = {phys_bank, coef_idx[7:0]};

  // Datapath reads the owned bank in adaptive mode, else the first bank
  assign dp_addr = {ADAPTIVE_EN & BANK_FLAG, DP_COEF_INDEX};

  // Exchange happens on a frame boundary only with adaptive mode on
  assign swap_do = SWAP_PENDING && ADAPTIVE_EN && FRAME_SYNC;
  // A request counts only if the same write leaves adaptive mode on, else it could never run
  assign swap_set = cfg_wr && WRITEDATA[`ACB_CFG_SWAP_BIT] && WRITEDATA[`ACB_CFG_EN_BIT];

  // Coefficient store
  acb_coef_mem u_mem (
    .clk(CLK_SYS),
    .host_we(mem_we),
    .host_addr(host_addr),
    .host_wdata({stage_hi, stage_mid, WRITEDATA[7:0]}),
    .host_rdata(host_rdata),
    .dp_addr(dp_addr),
    .dp_rdata(DP_COEF)
  );

  // Avalon handshake: one cycle to launch the read, one to present the answer
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      state <= `ACB_ST_IDLE;
      WAITREQUEST <= 1'b1;
      READDATA <= `ACB_READ_ZERO;
    end else begin
      case (state)
        `ACB_ST_IDLE: begin
          if (READ || WRITE) begin
            state <= `ACB_ST_BUSY;
          end
        end
        `ACB_ST_BUSY: begin
          state <= `ACB_ST_ACK;
          WAITREQUEST <= 1'b0;
          if (READ) begin
            READDATA <= {24'h00_0000, rd_byte};
          end else begin
            READDATA <= `ACB_READ_ZERO;
          end
        end
        `ACB_ST_ACK: begin
          // Master drops the request at this edge, so go back to waiting
          state <= `ACB_ST_IDLE;
          WAITREQUEST <= 1'b1;
        end
        default: begin
          state <= `ACB_ST_IDLE;
          WAITREQUEST <= 1'b1;
        end
      endcase
    end
  end

  // Page select, shared by every page
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      page <= `ACB_PAGE_RST;
    end else if (wr_take && is_page_sel) begin
      page <= WRITEDATA[7:0];
    end
  end

  // Adaptive enable
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      ADAPTIVE_EN <= `ACB_CFG_RST;
    end else if (cfg_wr) begin
      ADAPTIVE_EN <= WRITEDATA[`ACB_CFG_EN_BIT];
    end
  end

  // Swap request: a new host set wins over the self-clear in the same cycle
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      SWAP_PENDING <= `ACB_CFG_RST;
    end else if (swap_set) begin
      SWAP_PENDING <= 1'b1;
    end else if (cfg_wr && !WRITEDATA[`ACB_CFG_EN_BIT]) begin
      // Leaving adaptive mode drops a request that could never run
      SWAP_PENDING <= 1'b0;
    end else if (swap_do) begin
      SWAP_PENDING <= 1'b0;
    end
  end

  // Bank ownership flag, read-only to the host
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      BANK_FLAG <= `ACB_CFG_RST;
    end else if (swap_do) begin
      BANK_FLAG <= ~BANK_FLAG;
    end
  end

  // Byte staging for the coefficient under construction
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      stage_hi <= 8'h00;
      stage_mid <= 8'h00;
    end else if (wr_take && coef_ok) begin
      if (lane == `ACB_LANE_HI) begin
        stage_hi <= WRITEDATA[7:0];
      end
      if (lane == `ACB_LANE_MID) begin
        stage_mid <= WRITEDATA[7:0];
      end
    end
  end

  // One-cycle flag when a coefficient access is refused for a running ADC
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      ACCESS_DENIED <= 1'b0;
    end else begin
      ACCESS_DENIED <= (state == `ACB_ST_ACK) && (READ || WRITE) && coef_hit && !grant;
    end
  end

endmodule

/* File: core/acb_coef_mem.v */
// Two-bank coefficient store with one host port and one datapath read port
`timescale 1ns/1ps

module acb_coef_mem (
  input wire clk,
  input wire host_we,
  input wire [8:0] host_addr,
  input wire [23:0] host_wdata,
  output reg [23:0] host_rdata,
  input wire [8:0] dp_addr,
  output reg [23:0] dp_rdata
);

  // Bit 8 of an address picks the bank; contents are undefined after reset
  reg [23:0] store [0:511];

  // Host port, read-before-write so a read never sees a half update
  always @(posedge clk) begin
    if (host_we) begin
      store[host_addr] <= host_wdata;
    end
    host_rdata <= store[host_addr];
  end

  // Datapath port, registered so the coefficient output comes from a flop
  always @(posedge clk) begin
    dp_rdata <= store[dp_addr];
  end

endmodule

/* File: core/acb_regs.vh */
// Register offsets, field positions, reset values and page map of the coefficient bank
`ifndef ACB_REGS_VH
`define ACB_REGS_VH

// Register offsets inside every page (register index, byte address is four times it)
`define ACB_OFS_PAGE_SEL 7'h00
`define ACB_OFS_CFG 7'h01
`define ACB_OFS_RSVD_FIRST 7'h02
`define ACB_OFS_RSVD_LAST 7'h07
`define ACB_OFS_COEF 7'h08

// Pages holding the configuration register and the two banks
`define ACB_PAGE_CFG 8'h08
`define ACB_PAGE_FIRST_LO 8'h08
`define ACB_PAGE_FIRST_HI 8'h10
`define ACB_PAGE_SECOND_LO 8'h1A
`define ACB_PAGE_SECOND_HI 8'h22

// Coefficient layout: four byte slots per coefficient, thirty per page
`define ACB_COEF_PER_PAGE 5'h1E
`define ACB_COEF_LAST 9'h0FF
`define ACB_LANE_HI 2'h0
`define ACB_LANE_MID 2'h1
`define ACB_LANE_LO 2'h2

// Configuration register fields
`define ACB_CFG_SWAP_BIT 0
`define ACB_CFG_FLAG_BIT 1
`define ACB_CFG_EN_BIT 2

// Reset values
`define ACB_PAGE_RST 8'h00
`define ACB_CFG_RST 1'b0
`define ACB_READ_ZERO 32'h0000_0000

// Bus handshake states
`define ACB_ST_IDLE 2'h0
`define ACB_ST_BUSY 2'h1
`define ACB_ST_ACK 2'h2

`endif

/* File: tb/acb_coef_bank_properties.sv */
// Checker for bus timing, bank swap and access refusal of the coefficient bank
`timescale 1ns/1ps
module acb_chk (
  input wire CLK_SYS,
  input wire NRST,
  input wire [6:0] ADDRESS,
  input wire READ,
  input wire WRITE,
  input wire [31:0] READDATA,
  input wire WAITREQUEST,
  input wire ADC_POWERED,
  input wire FRAME_SYNC,
  input wire ADAPTIVE_EN,
  input wire BANK_FLAG,
  input wire SWAP_PENDING,
  input wire ACCESS_DENIED
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST);
  // A host write in the answer cycle may set the request again, so it is excluded
  wire swap = SWAP_PENDING && ADAPTIVE_EN && FRAME_SYNC;
  wire wr_done = WRITE && !WAITREQUEST;
  property p_wait; $rose(READ || WRITE) |-> WAITREQUEST ##1 WAITREQUEST ##1 !WAITREQUEST;
  endproperty
  property p_pend; SWAP_PENDING |-> ADAPTIVE_EN; endproperty
  property p_toggle; swap |=> BANK_FLAG != $past(BANK_FLAG); endproperty
  property p_clear; swap && !wr_done |=> !SWAP_PENDING; endproperty
  property p_flag; !swap |=> $stable(BANK_FLAG); endproperty
  property p_hi0; READDATA[31:8] == 24'h00_0000; endproperty
  property p_deny; ACCESS_DENIED |-> !$past(WAITREQUEST) && !$past(ADAPTIVE_EN)
    && $past(ADC_POWERED) && $past(ADDRESS) >= 7'h08; endproperty
  property p_deny_rd; ACCESS_DENIED && $past(READ) |-> READDATA == 32'h0000_0000; endproperty
  property p_en; $changed(ADAPTIVE_EN) |-> $past(WRITE) && !$past(WAITREQUEST); endproperty
  a_wait: assert property (p_wait) else $error("answer not two edges after request");
  a_pend: assert property (p_pend) else $error("swap pending without adaptive");
  a_toggle: assert property (p_toggle) else $error("flag kept on swap");
  a_clear: assert property (p_clear) else $error("swap request kept");
  a_flag: assert property (p_flag) else $error("flag moved without swap");
  a_hi0: assert property (p_hi0) else $error("upper read bits set");
  a_deny: assert property (p_deny) else $error("refusal without cause");
  a_deny_rd: assert property (p_deny_rd) else $error("refused read not zero");
  a_en: assert property (p_en) else $error("enable moved without write");
  c_swap: cover property (swap);
  c_deny: cover property (ACCESS_DENIED);
  c_read: cover property (READ && !WAITREQUEST);
endmodule

bind acb_coef_bank acb_chk chk_u (.CLK_SYS, .NRST, .ADDRESS, .READ, .WRITE, .READDATA,
  .WAITREQUEST, .ADC_POWERED, .FRAME_SYNC, .ADAPTIVE_EN, .BANK_FLAG, .SWAP_PENDING,
  .ACCESS_DENIED);

/* File: tb/acb_host.sv */
// Host model: an Avalon-MM master issuing one register access at a time
`timescale 1ns/1ps
module acb_host (
  input wire clk,
  input wire waitrequest,
  input wire [31:0] readdata,
  output reg [6:0] address = 7'h00,
  output reg read = 1'b0,
  output reg write = 1'b0,
  output reg [31:0] writedata = 32'h0000_0000
);
  // Request held until waitrequest is sampled low, so slow answers are never cut short
  task xfer(input logic we, input logic [6:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge clk);
    address <= a;
    read <= !we;
    write <= we;
    writedata <= {24'h00_0000, d};
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the paged coefficient double-buffer
`timescale 1ns/1ps
module tb;
  logic clk = 0, nrst = 0, adc_pwr = 0, frame = 0, rd, wr, wait_req, adapt, flag, pend;
  logic denied;
  int n_deny = 0;
  logic [6:0] addr;
  logic [31:0] wdata, rdata;
  logic [7:0] dp_idx = 8'h00;
  logic [23:0] dp_coef;
  int bad_count = 0, n_tests = 0;
  // Row: {write, address}, data, expected read byte
  localparam int NR = 27;
  logic [23:0] rows [NR] = '{
    24'h80_0800, 24'h00_0008, 24'h01_0000, 24'h03_0000, 24'h81_0100, 24'h01_0000,
    24'h88_1200, 24'h89_3400, 24'h8A_5600, 24'h08_0012, 24'h0A_0056, 24'h0B_0000,
    24'h88_AA00, 24'h08_0012, 24'h80_0900, 24'h88_0100, 24'h89_0200, 24'h8A_0300,
    24'h01_0000, 24'h80_1A00, 24'h88_4400, 24'h89_5500, 24'h8A_6600, 24'h08_0044,
    24'h80_1100, 24'h08_0000, 24'h80_0800};
  initial forever #10 clk = ~clk;
  acb_coef_bank dut_u (.CLK_SYS(clk), .NRST(nrst), .ADDRESS(addr), .READ(rd), .WRITE(wr),
    .BYTEENABLE(4'h1), .WRITEDATA(wdata), .READDATA(rdata), .WAITREQUEST(wait_req),
    .ADC_POWERED(adc_pwr), .FRAME_SYNC(frame), .DP_COEF_INDEX(dp_idx), .DP_COEF(dp_coef),
    .ADAPTIVE_EN(adapt), .BANK_FLAG(flag), .SWAP_PENDING(pend), .ACCESS_DENIED(denied));
  // Refusal pulses last one cycle, so they are counted as they happen
  always @(posedge clk) if (denied === 1'b1) n_deny <= n_deny + 1;
  acb_host host_u (.clk(clk), .waitrequest(wait_req), .readdata(rdata), .address(addr),
    .read(rd), .write(wr), .writedata(wdata));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus access; reads are compared against the row's byte
  task acc(input logic [23:0] row);
    logic [31:0] q;
    host_u.xfer(row[23], row[22:16], row[15:8], q);
    if (!row[23]) chk(q, {24'h00_0000, row[7:0]});
  endtask
  // Datapath word seen two edges after the index, one for the index, one for the read
  task dp(input logic [7:0] i, input logic [23:0] e);
    dp_idx <= i;
    repeat (2) @(posedge clk);
    chk({8'h00, dp_coef}, {8'h00, e});
  endtask
  task finish_test;
    $display("Checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Main sequence: table first, then refusal, swap and reset by hand
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < NR; i++) acc(rows[i]);
    dp(8'h00, 24'h12_3456);
    dp(8'h1E, 24'h01_0203);
    adc_pwr <= 1'b1;
    acc(24'h08_0000);
    acc(24'h8A_FF00);
    adc_pwr <= 1'b0;
    acc(24'h0A_0056);
    adc_pwr <= 1'b1;
    acc(24'h81_0600);
    acc(24'h01_0004);
    acc(24'h08_0044);
    acc(24'h88_1100);
    acc(24'h89_2200);
    acc(24'h8A_3300);
    dp(8'h00, 24'h12_3456);
    acc(24'h81_0500);
    acc(24'h01_0005);
    frame <= 1'b1;
    @(posedge clk);
    frame <= 1'b0;
    acc(24'h01_0006);
    dp(8'h00, 24'h11_2233);
    acc(24'h08_0012);
    nrst <= 1'b0;
    // Two edges in reset so no checker attempt starts across a one-cycle pulse
    repeat (2) @(posedge clk);
    chk({wait_req, adapt, flag, pend, rdata[27:0]}, 32'h8000_0000);
    nrst <= 1'b1;
    @(posedge clk);
    acc(24'h00_0000);
    acc(24'h80_0800);
    acc(24'h01_0000);
    chk(n_deny, 32'd2);
    finish_test();
  end
  // Watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    #100_000;
    bad_count++;
    finish_test();
  end
endmodule
